// [core/fpm_pkg.sv]
package fpm_pkg;

	// ========================================
	// timing
	localparam int REF_CLK_MHZ    = 50;
	localparam int SETTLE_TIME_US = 1000;
	localparam int SETTLE_CYC     = SETTLE_TIME_US * REF_CLK_MHZ;
	localparam int STARTUP_CYC    = 3;

	// ========================================
	// pulse counts
	localparam logic [3:0] PULSES_CSI    = 4'h0;
	localparam logic [3:0] PULSES_CSI_HS = 4'h3;
	localparam logic [3:0] PULSES_A      = 4'h8;
	localparam logic [3:0] PULSES_B      = 4'h9;
	localparam logic [3:0] PULSES_A_HS   = 4'hB;
	localparam logic [3:0] PULSES_OVER   = 4'hC;

	// ========================================
	// widths and reset values
	localparam int          BIT_W       = 16;
	localparam logic [15:0] BIT_CNT_MAX = 16'hFFFF;
	localparam int          APP_W       = 8;
	localparam logic [7:0]  APP_OUT_RST = 8'h00;
	localparam logic [7:0]  APP_OE_RST  = 8'h00;

	// ========================================
	// types
	typedef enum logic [2:0] {
		MODE_NONE                          = 3'b000,
		MODE_CLOCKED_SERIAL_CHANNEL        = 3'b001,
		MODE_CLOCKED_SERIAL_WITH_HANDSHAKE = 3'b010,
		MODE_ASYNC_CHANNEL_A               = 3'b011,
		MODE_ASYNC_CHANNEL_B               = 3'b100,
		MODE_ASYNC_CHANNEL_A_WITH_HANDSHAKE = 3'b101
	} mode_t;

	typedef enum logic [2:0] {
		ST_START   = 3'b000,
		ST_NORMAL  = 3'b001,
		ST_COUNT   = 3'b010,
		ST_WAIT_RX = 3'b011,
		ST_MEASURE = 3'b100,
		ST_READY   = 3'b101
	} state_t;

	typedef struct packed {
		logic serial_data_out;
		logic serial_data_out_oe;
		logic async_a_transmit;
		logic async_a_transmit_oe;
		logic async_b_transmit;
		logic async_b_transmit_oe;
		logic handshake_pin;
		logic handshake_pin_oe;
	} ser_pins_t;

	typedef struct packed {
		logic serial_data_in;
		logic serial_clock_pin;
		logic async_a_receive;
		logic async_b_receive;
	} ser_in_t;

	localparam ser_pins_t SER_PINS_RST = 8'h00;
	localparam ser_in_t   SER_IN_RST   = 4'h0;

endpackage : fpm_pkg

// [core/flash_program_mode_select.sv]
`timescale 1ns/1ns

module flash_program_mode_select
	import fpm_pkg::*;
#(
	parameter int SETTLE_CYC_P = SETTLE_CYC
) (
	// clocks and reset
	input  wire logic             ref_clk_i,
	input  wire logic             resetn_i,
	input  wire logic             link_clk_i,
	// programmer pins
	input  wire logic             vpp_i,
	input  wire ser_in_t          ser_in_i,
	output ser_pins_t             ser_o,
	// command engine side
	input  wire logic             cmd_tx_i,
	input  wire logic             cmd_hs_ready_i,
	output logic                  cmd_rx_o,
	output logic                  cmd_sck_o,
	// status
	output logic                  prog_mode_o,
	output mode_t                 mode_o,
	output logic                  mode_valid_o,
	output logic [BIT_W-1:0]      rx_bit_cycles_o,
	output logic                  rx_rate_valid_o,
	// ordinary port pins
	input  wire logic [APP_W-1:0] app_out_i,
	input  wire logic [APP_W-1:0] app_oe_i,
	output logic [APP_W-1:0]      app_out_o,
	output logic [APP_W-1:0]      app_oe_o
);

	// ========================================
	// decode
	function automatic mode_t decode_mode(input logic [3:0] n);
		case (n)
			PULSES_CSI:    decode_mode = MODE_CLOCKED_SERIAL_CHANNEL;
			PULSES_CSI_HS: decode_mode = MODE_CLOCKED_SERIAL_WITH_HANDSHAKE;
			PULSES_A:      decode_mode = MODE_ASYNC_CHANNEL_A;
			PULSES_B:      decode_mode = MODE_ASYNC_CHANNEL_B;
			PULSES_A_HS:   decode_mode = MODE_ASYNC_CHANNEL_A_WITH_HANDSHAKE;
			default:       decode_mode = MODE_NONE;
		endcase
	endfunction : decode_mode

	function automatic logic is_async(input mode_t m);
		is_async = (m == MODE_ASYNC_CHANNEL_A) || (m == MODE_ASYNC_CHANNEL_B)
			|| (m == MODE_ASYNC_CHANNEL_A_WITH_HANDSHAKE);
	endfunction : is_async

	// ========================================
	// declarations
	state_t           state;
	logic [1:0]       start_cnt;
	logic [16:0]      settle_cnt;
	logic [3:0]       pulse_cnt;
	logic [BIT_W-1:0] bit_cnt;
	ser_in_t          in_s1, in_s2;
	logic             count_en, pulse_evt, rx_sel, start_done, settle_done;
	logic             vpp_s1, vpp_s2, tgl_s1, tgl_s2, tgl_s3;
	logic             vpp_l1, vpp_l2, vpp_l3, en_l1, en_l2, lrst_s1, lrst_n, pulse_tgl;

	// ========================================
	// link domain: reset release, pin sync, pulse detect
	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lrst_s1 <= 1'b0;
			lrst_n  <= 1'b0;
		end else begin
			lrst_s1 <= 1'b1;
			lrst_n  <= lrst_s1;
		end
	end

	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			vpp_l1 <= 1'b0;
			vpp_l2 <= 1'b0;
			vpp_l3 <= 1'b0;
			en_l1  <= 1'b0;
			en_l2  <= 1'b0;
		end else begin
			vpp_l1 <= vpp_i;
			vpp_l2 <= vpp_l1;
			vpp_l3 <= vpp_l2;
			en_l1  <= count_en;
			en_l2  <= en_l1;
		end
	end
	// one toggle per low-going pulse while counting is open
	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			pulse_tgl <= 1'b0;
		end else if (en_l2 && vpp_l3 && !vpp_l2) begin
			pulse_tgl <= ~pulse_tgl;
		end
	end

	a_pulse_toggle: assert property (
		@(posedge link_clk_i) disable iff (!lrst_n)
		(en_l2 && vpp_l3 && !vpp_l2) |=> (pulse_tgl != $past(pulse_tgl)))
		else $error("pulse on voltage pin not signalled");

	// ========================================
	// reference domain synchronisers
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vpp_s1 <= 1'b0;
			vpp_s2 <= 1'b0;
			in_s1  <= SER_IN_RST;
			in_s2  <= SER_IN_RST;
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
		end else begin
			vpp_s1 <= vpp_i;
			vpp_s2 <= vpp_s1;
			in_s1  <= ser_in_i;
			in_s2  <= in_s1;
			tgl_s1 <= pulse_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
		end
	end

	assign pulse_evt   = tgl_s2 ^ tgl_s3;
	assign rx_sel      = (mode_o == MODE_ASYNC_CHANNEL_B) ? in_s2.async_b_receive
		: in_s2.async_a_receive;
	assign start_done  = (start_cnt == 2'(STARTUP_CYC - 1));
	assign settle_done = (settle_cnt == 17'(SETTLE_CYC_P - 1));

	// ========================================
	// sequence control
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state       <= ST_START;
			start_cnt   <= 2'h0;
			prog_mode_o <= 1'b0;
			count_en    <= 1'b0;
		end else begin
			case (state)
				ST_START: begin
					start_cnt <= start_cnt + 2'h1;
					if (start_done && vpp_s2) begin
						state       <= ST_COUNT;
						prog_mode_o <= 1'b1;
						count_en    <= 1'b1;
					end else if (start_done) begin
						state <= ST_NORMAL;
					end
				end
				ST_COUNT: begin
					if (!pulse_evt && settle_done) begin
						count_en <= 1'b0;
						state    <= is_async(decode_mode(pulse_cnt)) ? ST_WAIT_RX : ST_READY;
					end
				end
				ST_WAIT_RX: begin
					if (!rx_sel) begin
						state <= ST_MEASURE;
					end
				end
				ST_MEASURE: begin
					if (rx_sel) begin
						state <= ST_READY;
					end
				end
				ST_NORMAL, ST_READY: state <= state;
				default:             state <= ST_START;
			endcase
		end
	end

	a_entry_on_vpp: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(state == ST_START && start_done && vpp_s2) |=> (prog_mode_o && count_en))
		else $error("programming mode not entered");
	a_no_entry_low: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(state == ST_START && start_done && !vpp_s2) |=>
		(state == ST_NORMAL && !prog_mode_o)[*4])
		else $error("programming mode entered without voltage");

	// ========================================
	// pulse counting and settle timer
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pulse_cnt  <= 4'h0;
			settle_cnt <= 17'h00000;
		end else if (state == ST_COUNT) begin
			if (pulse_evt) begin
				settle_cnt <= 17'h00000;
				if (pulse_cnt != PULSES_OVER) begin
					pulse_cnt <= pulse_cnt + 4'h1;
				end
			end else if (!settle_done) begin
				settle_cnt <= settle_cnt + 17'h00001;
			end
		end
	end

	a_pulse_count: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(state == ST_COUNT && pulse_evt && pulse_cnt < PULSES_OVER) |=>
		(pulse_cnt == $past(pulse_cnt) + 4'h1))
		else $error("pulse count did not advance");

	// ========================================
	// mode latch
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_o       <= MODE_NONE;
			mode_valid_o <= 1'b0;
		end else if (state == ST_COUNT && !pulse_evt && settle_done) begin
			mode_o       <= decode_mode(pulse_cnt);
			mode_valid_o <= 1'b1;
		end
	end

	a_mode_decode: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(mode_valid_o) |-> (mode_o == decode_mode(pulse_cnt)))
		else $error("mode does not match pulse count");

	// ========================================
	// receive bit time from the reset command start bit
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt         <= '0;
			rx_bit_cycles_o <= '0;
			rx_rate_valid_o <= 1'b0;
		end else if (state == ST_WAIT_RX) begin
			bit_cnt <= 16'h0001;
		end else if (state == ST_MEASURE) begin
			if (rx_sel) begin
				rx_bit_cycles_o <= bit_cnt;
				rx_rate_valid_o <= 1'b1;
			end else if (bit_cnt != BIT_CNT_MAX) begin
				bit_cnt <= bit_cnt + 16'h0001;
			end
		end
	end

	sequence s_start_low;
		(state == ST_MEASURE && !rx_sel)[*3];
	endsequence
	sequence s_start_end;
		(state == ST_MEASURE && rx_sel);
	endsequence
	a_rate_measured: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		s_start_low ##1 s_start_end |=>
		(rx_rate_valid_o && rx_bit_cycles_o == $past(bit_cnt) && state == ST_READY))
		else $error("receive bit time not captured");

	// ========================================
	// channel pin routing
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ser_o     <= SER_PINS_RST;
			cmd_rx_o  <= 1'b1;
			cmd_sck_o <= 1'b0;
		end else begin
			ser_o     <= SER_PINS_RST;
			cmd_rx_o  <= 1'b1;
			cmd_sck_o <= 1'b0;
			if (mode_valid_o) begin
				case (mode_o)
					MODE_CLOCKED_SERIAL_CHANNEL,
					MODE_CLOCKED_SERIAL_WITH_HANDSHAKE: begin
						ser_o.serial_data_out    <= cmd_tx_i;
						ser_o.serial_data_out_oe <= 1'b1;
						cmd_rx_o                 <= in_s2.serial_data_in;
						cmd_sck_o                <= in_s2.serial_clock_pin;
					end
					MODE_ASYNC_CHANNEL_A,
					MODE_ASYNC_CHANNEL_A_WITH_HANDSHAKE: begin
						ser_o.async_a_transmit    <= cmd_tx_i;
						ser_o.async_a_transmit_oe <= 1'b1;
						cmd_rx_o                  <= in_s2.async_a_receive;
					end
					MODE_ASYNC_CHANNEL_B: begin
						ser_o.async_b_transmit    <= cmd_tx_i;
						ser_o.async_b_transmit_oe <= 1'b1;
						cmd_rx_o                  <= in_s2.async_b_receive;
					end
					default: cmd_rx_o <= 1'b1;
				endcase
				if (mode_o == MODE_CLOCKED_SERIAL_WITH_HANDSHAKE ||
					mode_o == MODE_ASYNC_CHANNEL_A_WITH_HANDSHAKE) begin
					ser_o.handshake_pin    <= cmd_hs_ready_i;
					ser_o.handshake_pin_oe <= 1'b1;
				end
			end
		end
	end

	a_hs_driven: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(mode_valid_o && mode_o == MODE_CLOCKED_SERIAL_WITH_HANDSHAKE) |=>
		(ser_o.handshake_pin_oe && ser_o.serial_data_out_oe && !ser_o.async_a_transmit_oe))
		else $error("handshake channel pins not driven");
	a_invalid_silent: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(mode_valid_o && mode_o == MODE_NONE) |=> (ser_o == SER_PINS_RST && prog_mode_o))
		else $error("channel enabled for undefined count");

	// ========================================
	// ordinary pins: passed only in normal operation
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			app_out_o <= APP_OUT_RST;
			app_oe_o  <= APP_OE_RST;
		end else if (state == ST_NORMAL) begin
			app_out_o <= app_out_i;
			app_oe_o  <= app_oe_i;
		end else begin
			app_out_o <= APP_OUT_RST;
			app_oe_o  <= APP_OE_RST;
		end
	end

	a_app_pins_held: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		prog_mode_o |=> (app_oe_o == APP_OE_RST && app_out_o == APP_OUT_RST))
		else $error("ordinary pin left reset state in programming mode");

endmodule : flash_program_mode_select

// [bench/prog_model.sv]
`timescale 1ns/1ns

// ========================================
// external programmer: entry level, mode pulses, reset command start bit
module prog_model
	import fpm_pkg::*;
(
	// clocks
	input  wire logic ref_clk_i,
	input  wire logic link_clk_i,
	// pins toward the device
	output logic      vpp_o,
	output ser_in_t   ser_o
);
	// serial lines idle high, serial clock stands high between frames
	initial begin
		vpp_o = 1'b0;
		ser_o = 4'hF;
	end

	task automatic set_vpp(input logic v);
		vpp_o = v;
	endtask : set_vpp

	task automatic set_lines(input ser_in_t v);
		ser_o = v;
	endtask : set_lines

	// pulses only once entry is done; each phase spans 4 link cycles
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge link_clk_i);
			#1 vpp_o = 1'b0;
			repeat (4) @(posedge link_clk_i);
			#1 vpp_o = 1'b1;
		end
	endtask : pulses

	// start bit of the first reset command, whose lsb is 1
	task automatic start_bit(input int len);
		@(posedge ref_clk_i);
		#1 ser_o[1:0] = 2'b00;
		repeat (len) @(posedge ref_clk_i);
		#1 ser_o[1:0] = 2'b11;
	endtask : start_bit
endmodule : prog_model

// [bench/flash_program_mode_select_bench.sv]
`timescale 1ns/1ns

module flash_program_mode_select_bench;
	import fpm_pkg::*;
	localparam int SETTLE = 64;

	logic        ref_clk_i = 1'b0;
	logic        link_clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        vpp_i;
	ser_in_t     ser_in_i;
	ser_pins_t   ser_o;
	logic        cmd_tx_i = 1'b0;
	logic        cmd_hs_ready_i = 1'b0;
	logic        cmd_rx_o;
	logic        cmd_sck_o;
	logic        prog_mode_o;
	mode_t       mode_o;
	logic        mode_valid_o;
	logic [15:0] rx_bit_cycles_o;
	logic        rx_rate_valid_o;
	logic [7:0]  app_out_i = 8'h00;
	logic [7:0]  app_oe_i = 8'h00;
	logic [7:0]  app_out_o;
	logic [7:0]  app_oe_o;
	int          fails = 0;
	int          total_checks = 0;

	always #10 ref_clk_i = ~ref_clk_i;
	always begin
		#3 link_clk_i = 1'b1;
		#7 link_clk_i = 1'b0;
		#5;
	end

	flash_program_mode_select #(.SETTLE_CYC_P(SETTLE)) uut (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
		.vpp_i(vpp_i), .ser_in_i(ser_in_i), .ser_o(ser_o), .cmd_tx_i(cmd_tx_i),
		.cmd_hs_ready_i(cmd_hs_ready_i), .cmd_rx_o(cmd_rx_o), .cmd_sck_o(cmd_sck_o),
		.prog_mode_o(prog_mode_o), .mode_o(mode_o), .mode_valid_o(mode_valid_o),
		.rx_bit_cycles_o(rx_bit_cycles_o), .rx_rate_valid_o(rx_rate_valid_o),
		.app_out_i(app_out_i), .app_oe_i(app_oe_i), .app_out_o(app_out_o),
		.app_oe_o(app_oe_o)
	);

	prog_model prog (
		.ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i), .vpp_o(vpp_i), .ser_o(ser_in_i)
	);

	// ========================================
	// shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	// the bench drives reset; the programmer only sets the voltage pin level
	task automatic do_reset(input logic v);
		@(posedge ref_clk_i);
		#1 resetn_i = 1'b0;
		prog.set_vpp(v);
		repeat (3) @(posedge ref_clk_i);
		#1 resetn_i = 1'b1;
		repeat (12) @(posedge ref_clk_i);
		#1;
	endtask : do_reset

	// ========================================
	// scenarios
	task automatic test_normal();
		do_reset(1'b0);
		app_out_i = 8'hA5;
		app_oe_i = 8'h3C;
		repeat (3) @(posedge ref_clk_i);
		#1;
		check(prog_mode_o, 1'b0, "normal entry");
		check({app_out_o, app_oe_o}, 16'hA53C, "normal ports");
		check(ser_o, 8'h00, "normal pins");
		$display("test_normal done");
	endtask : test_normal

	task automatic test_mode(input int n, input mode_t m, input logic [7:0] pins,
		input logic async_m);
		int w;
		do_reset(1'b1);
		check(prog_mode_o, 1'b1, "entry");
		prog.pulses(n);
		w = 0;
		while (mode_valid_o !== 1'b1 && w < 4 * SETTLE) begin
			@(posedge ref_clk_i);
			#1;
			w++;
		end
		check(mode_valid_o, 1'b1, "mode valid");
		check(mode_o, m, "mode");
		prog.pulses(1);
		cmd_tx_i = 1'b1;
		cmd_hs_ready_i = 1'b1;
		app_out_i = 8'hFF;
		app_oe_i = 8'hFF;
		repeat (4) @(posedge ref_clk_i);
		#1;
		check(ser_o, pins, "pins tx high");
		check(cmd_sck_o, pins[6], "sck");
		check(cmd_rx_o, 1'b1, "rx idle");
		check({app_out_o, app_oe_o}, 16'h0000, "ports");
		cmd_tx_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1;
		check(ser_o, pins & 8'h57, "pins tx low");
		if (async_m) begin
			prog.start_bit(40);
			repeat (6) @(posedge ref_clk_i);
			#1;
			check(rx_rate_valid_o, 1'b1, "rate valid");
			check(rx_bit_cycles_o >= 16'h0027 && rx_bit_cycles_o <= 16'h0029, 1'b1, "rate");
		end
		prog.set_lines(4'h0);
		repeat (4) @(posedge ref_clk_i);
		#1;
		check(cmd_rx_o, m == MODE_NONE, "rx low");
		check(cmd_sck_o, 1'b0, "sck low");
		if (!async_m)
			check(rx_rate_valid_o, 1'b0, "no rate");
		prog.set_lines(4'hF);
		repeat (SETTLE + 8) @(posedge ref_clk_i);
		#1;
		check(mode_o, m, "late pulse ignored");
		$display("test_mode %0d done", n);
	endtask : test_mode

	// ========================================
	// main sequence and watchdog
	initial begin
		test_normal();
		test_mode(0, MODE_CLOCKED_SERIAL_CHANNEL, 8'hC0, 1'b0);
		test_mode(3, MODE_CLOCKED_SERIAL_WITH_HANDSHAKE, 8'hC3, 1'b0);
		test_mode(8, MODE_ASYNC_CHANNEL_A, 8'h30, 1'b1);
		test_mode(9, MODE_ASYNC_CHANNEL_B, 8'h0C, 1'b1);
		test_mode(11, MODE_ASYNC_CHANNEL_A_WITH_HANDSHAKE, 8'h33, 1'b1);
		test_mode(5, MODE_NONE, 8'h00, 1'b0);
		test_mode(13, MODE_NONE, 8'h00, 1'b0);
		test_done();
	end

	initial begin
		#200000;
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		test_done();
	end
endmodule : flash_program_mode_select_bench
